// File: core/mucp_top.sv
// mucp_top: user command channel and link monitor of an mdio controller
// assumes an avalon-mm master with waitrequest and one external phy bus
`timescale 1ns/1ps

// Operation
// - writing 1 to launch schedules one access, run when the engine is free
// - writing 0 to launch is ignored and cancels nothing
// - launch is only accepted while the state machine is enabled
// - launch clears itself when the access has completed
// - while launch is 1, writes to the command register are discarded
// - direction bit 1 means register write, 0 means register read
// - after a read, acknowledge shows whether the phy acknowledged
// - register index field selects the phy register
// - port index field selects the phy address
// - data field is sent on writes and loaded with read data
// - link source select reads 0; only state machine link status exists
// - link change interrupts raised only while link change enable is 1
// - link status is polled from the phy named in the monitor field
// - completion raises a command done event, gated onto irq by its mask
module mucp_top
  #(parameter int MDC_HALF = mucp_pkg::MDC_HALF_CYC)
  (
   input  wire logic                   clk,         // 40 MHz system clock
   input  wire logic                   rst_b,       // async reset, active low
   input  wire logic [mucp_pkg::AW-1:0] address,    // byte address
   input  wire logic                   read,        // avalon read
   input  wire logic                   write,       // avalon write
   input  wire logic [31:0]            writedata,   // avalon write data
   input  wire logic [3:0]             byteenable,  // avalon byte lanes
   output logic [31:0]                 readdata,    // avalon read data
   output logic                        waitrequest, // avalon stall
   output logic                        irq,         // level interrupt
   output logic                        mdc,         // management clock
   input  wire logic                   mdioIn,      // data pin input
   output logic                        mdioOut,     // data pin output
   output logic                        mdioOe       // data pin enable
  );
   import mucp_pkg::*;

   typedef struct packed {
      logic        go;
      logic        wr;
      logic        ack;
      logic [4:0]  regIdx;
      logic [4:0]  phyIdx;
      logic [15:0] data;
      logic        linkIrqEn;
      logic [4:0]  monPhy;
      logic        enable;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic        linkUp;
      logic        engBusy;
      logic        engUser;
      logic        start;
      logic        meta;
      logic        sync;
      logic [31:0] rdata;
      logic        wreq;
      logic        irq;
   } mucp_top_st_t;

   mucp_top_st_t q;
   mucp_top_st_t d;

   logic        wrAcc;
   logic        cmdWr;
   logic [31:0] cmdRd;
   logic [31:0] selRd;
   logic [31:0] cmdNew;
   logic [31:0] selNew;
   logic [31:0] ctlNew;
   logic [31:0] maskNew;
   logic        fWr;
   logic [4:0]  fPhy;
   logic [4:0]  fReg;
   logic        fDone;
   logic        fAck;
   logic [15:0] fRd;
   logic        fMdc;
   logic        fOut;
   logic        fOe;

   function automatic logic [31:0] mucp_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   // a write takes effect at the edge where waitrequest is seen low
   assign wrAcc = write && !q.wreq;
   assign cmdWr = wrAcc && (address == OFS_CMD);

   assign cmdRd = {q.go, q.wr, q.ack, 3'h0, q.regIdx, q.phyIdx, q.data};
   // link source select is not stored, always reads 0
   assign selRd = {24'h00_0000, 1'b0, q.linkIrqEn, 1'b0, q.monPhy};

   assign cmdNew  = mucp_merge(cmdRd, writedata, byteenable);
   assign selNew  = mucp_merge(selRd, writedata, byteenable);
   assign ctlNew  = mucp_merge({31'h0000_0000, q.enable}, writedata, byteenable);
   assign maskNew = mucp_merge({30'h0000_0000, q.mask}, writedata, byteenable);

   // user fields while the command owns the engine, else the link poll
   assign fWr  = q.engUser ? q.wr : 1'b0;
   assign fPhy = q.engUser ? q.phyIdx : q.monPhy;
   assign fReg = q.engUser ? q.regIdx : PHY_STAT_REG;

   always_comb
   begin
      d       = q;
      d.start = 1'b0;
      d.meta  = mdioIn;
      d.sync  = q.meta;
      d.wreq  = 1'b1;

      // one wait cycle: read data is captured at the same edge where waitrequest drops
      if ((read || write) && q.wreq)
      begin
         d.wreq = 1'b0;
         case (address)
            OFS_CMD:  d.rdata = cmdRd;
            OFS_SEL:  d.rdata = selRd;
            OFS_CTL:  d.rdata = {30'h0000_0000, q.engBusy, q.enable};
            OFS_STAT: d.rdata = {30'h0000_0000, q.status};
            OFS_MASK: d.rdata = {30'h0000_0000, q.mask};
            OFS_LINK: d.rdata = {31'h0000_0000, q.linkUp};
            default:  d.rdata = REG_RST;
         endcase
      end

      // clear only what the read returned, so an event after capture survives
      if (read && !q.wreq && (address == OFS_STAT))
         d.status = q.status & ~q.rdata[1:0];

      if (cmdWr && !q.go)
      begin
         d.wr     = cmdNew[CMD_WR_BIT];
         d.ack    = cmdNew[CMD_ACK_BIT];
         d.regIdx = cmdNew[CMD_REG_LSB +: 5];
         d.phyIdx = cmdNew[CMD_PHY_LSB +: 5];
         d.data   = cmdNew[15:0];
         // a 0 never clears a launch; disabled engine refuses a 1
         if (cmdNew[CMD_GO_BIT] && q.enable)
            d.go = 1'b1;
      end
      // reserved bits are simply not stored
      if (wrAcc && (address == OFS_SEL))
      begin
         d.linkIrqEn = selNew[SEL_IRQEN_BIT];
         d.monPhy    = selNew[SEL_MON_LSB +: 5];
      end
      if (wrAcc && (address == OFS_CTL))
         d.enable = ctlNew[CTL_EN_BIT];
      if (wrAcc && (address == OFS_MASK))
         d.mask = maskNew[1:0];

      if (q.engBusy)
      begin
         if (fDone)
         begin
            d.engBusy = 1'b0;
            if (q.engUser)
            begin
               d.go = 1'b0;
               if (!q.wr)
               begin
                  d.data = fRd;
                  d.ack  = fAck;
               end
               d.status[ST_CMD_BIT] = 1'b1;
            end
            else if (fAck && (fRd[PHY_LINK_BIT] != q.linkUp))
            begin
               d.linkUp = fRd[PHY_LINK_BIT];
               if (q.linkIrqEn)
                  d.status[ST_LINK_BIT] = 1'b1;
            end
         end
      end
      else if (q.enable)
      begin
         // a pending command wins; otherwise keep polling the link
         d.start   = 1'b1;
         d.engBusy = 1'b1;
         d.engUser = q.go;
      end

      d.irq = |(q.status & q.mask);
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= d;
   end

   mucp_frame #(.HALF(MDC_HALF)) u_frame (
      .clk      (clk),
      .rst_b    (rst_b),
      .start    (q.start),
      .isWrite  (fWr),
      .phyIdx   (fPhy),
      .regIdx   (fReg),
      .wrData   (q.data),
      .mdioSync (q.sync),
      .done     (fDone),
      .ackSeen  (fAck),
      .rdData   (fRd),
      .mdc      (fMdc),
      .mdioOut  (fOut),
      .mdioOe   (fOe)
   );

   assign readdata    = q.rdata;
   assign waitrequest = q.wreq;
   assign irq         = q.irq;
   assign mdc         = fMdc;
   assign mdioOut     = fOut;
   assign mdioOe      = fOe;

   // checks; the launch bound assumes the default mdc divider
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   property p_cmd_frozen;
      q.go && cmdWr && !fDone |=> $stable(cmdRd);
   endproperty
   a_cmd_frozen: assert property (p_cmd_frozen)
      else $error("command register changed while launch was set");

   property p_go_zero;
      !q.go && cmdWr && !writedata[CMD_GO_BIT] |=> !q.go;
   endproperty
   a_go_zero: assert property (p_go_zero)
      else $error("write of 0 set the launch bit");

   property p_go_disabled;
      !q.enable && !q.go && cmdWr |=> !q.go;
   endproperty
   a_go_disabled: assert property (p_go_disabled)
      else $error("launch accepted while engine disabled");

   property p_go_set;
      q.enable && !q.go && cmdWr && writedata[CMD_GO_BIT] && byteenable[3]
         |=> q.go ##[1:600] (q.start && q.engUser);
   endproperty
   a_go_set: assert property (p_go_set)
      else $error("launch not taken or access never started");

   property p_go_clear;
      fDone && q.engUser |=> !q.go && q.status[ST_CMD_BIT];
   endproperty
   a_go_clear: assert property (p_go_clear)
      else $error("launch not cleared or done event missing at completion");

   property p_rd_data;
      fDone && q.engUser && !q.wr |=> (q.data == $past(fRd)) && (q.ack == $past(fAck));
   endproperty
   a_rd_data: assert property (p_rd_data)
      else $error("read data or acknowledge not loaded");

   property p_user_frame;
      q.start && q.engUser |-> (fPhy == q.phyIdx) && (fReg == q.regIdx) && (fWr == q.wr);
   endproperty
   a_user_frame: assert property (p_user_frame)
      else $error("user access launched with wrong fields");

   property p_poll_frame;
      q.start && !q.engUser |-> (fPhy == q.monPhy) && (fReg == PHY_STAT_REG) && !fWr;
   endproperty
   a_poll_frame: assert property (p_poll_frame)
      else $error("link poll aimed at wrong phy");

   property p_link_irq;
      !q.linkIrqEn && !q.status[ST_LINK_BIT] |=> !q.status[ST_LINK_BIT];
   endproperty
   a_link_irq: assert property (p_link_irq)
      else $error("link change event while disabled");

   property p_irq_out;
      q.irq == |($past(q.status) & $past(q.mask));
   endproperty
   a_irq_out: assert property (p_irq_out)
      else $error("irq does not follow masked status");

   c_user_read:  cover property (fDone && q.engUser && !q.wr);
   c_user_write: cover property (fDone && q.engUser && q.wr);
   c_link_event: cover property ($rose(q.status[ST_LINK_BIT]));
   c_blocked:    cover property (q.go && cmdWr);

endmodule

// File: core/mucp_pkg.sv
// mucp_pkg: shared constants of the mdio user command port
// assumes a 40 MHz system clock and a clause 22 management link
package mucp_pkg;

   // register map, byte addresses on a 32-bit avalon-mm slave
   localparam int         AW        = 8;
   localparam logic [7:0] OFS_CMD   = 8'h00;
   localparam logic [7:0] OFS_SEL   = 8'h04;
   localparam logic [7:0] OFS_CTL   = 8'h08;
   localparam logic [7:0] OFS_STAT  = 8'h0C;
   localparam logic [7:0] OFS_MASK  = 8'h10;
   localparam logic [7:0] OFS_LINK  = 8'h14;

   // field positions
   localparam int CMD_GO_BIT    = 31;
   localparam int CMD_WR_BIT    = 30;
   localparam int CMD_ACK_BIT   = 29;
   localparam int CMD_REG_LSB   = 21;
   localparam int CMD_PHY_LSB   = 16;
   localparam int SEL_IRQEN_BIT = 6;
   localparam int SEL_MON_LSB   = 0;
   localparam int CTL_EN_BIT    = 0;
   localparam int ST_CMD_BIT    = 0;
   localparam int ST_LINK_BIT   = 1;

   // every register and all control state comes up zero
   localparam logic [31:0] REG_RST = 32'h0000_0000;

   // link polling target inside the monitored phy
   localparam logic [4:0] PHY_STAT_REG  = 5'h01;
   localparam int         PHY_LINK_BIT  = 2;

   // management clock timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int MDC_PERIOD_NS = 200;
   localparam int MDC_HALF_CYC  = (MDC_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PH_W          = 8;

   // frame layout, 64 bits sent msb first
   localparam logic [31:0] FR_PREAMBLE = 32'hFFFF_FFFF;
   localparam logic [1:0]  FR_START    = 2'h1;
   localparam logic [1:0]  FR_OP_READ  = 2'h2;
   localparam logic [1:0]  FR_OP_WRITE = 2'h1;
   localparam logic [1:0]  FR_TA_DRIVE = 2'h2;
   localparam logic [5:0]  FR_TA_FIRST = 6'h2E;
   localparam logic [5:0]  FR_TA_LAST  = 6'h2F;
   localparam logic [5:0]  FR_DATA_1ST = 6'h30;
   localparam logic [5:0]  FR_LAST     = 6'h3F;

endpackage

// File: core/mucp_frame.sv
// mucp_frame: serialiser for one clause 22 read or write frame
// assumes mdioSync is already synchronised to clk; mdc comes from a divider
`timescale 1ns/1ps
module mucp_frame
  #(parameter int HALF = mucp_pkg::MDC_HALF_CYC)
  (
   input  wire logic        clk,      // system clock
   input  wire logic        rst_b,    // async reset, active low
   input  wire logic        start,    // one-cycle launch
   input  wire logic        isWrite,  // 1 write, 0 read
   input  wire logic [4:0]  phyIdx,   // target phy address
   input  wire logic [4:0]  regIdx,   // target register
   input  wire logic [15:0] wrData,   // data for a write
   input  wire logic        mdioSync, // synchronised data pin
   output logic             done,     // one-cycle end of frame
   output logic             ackSeen,  // phy drove turnaround low
   output logic [15:0]      rdData,   // data shifted in
   output logic             mdc,      // management clock
   output logic             mdioOut,  // data pin value
   output logic             mdioOe    // data pin driven
  );
   import mucp_pkg::*;

   localparam logic [PH_W-1:0] PH_HI  = PH_W'(HALF);
   localparam logic [PH_W-1:0] PH_END = PH_W'(2 * HALF - 1);

   typedef enum logic [0:0] {
      FR_IDLE = 1'b0,
      FR_RUN  = 1'b1
   } mucp_fr_state_t;

   typedef struct packed {
      mucp_fr_state_t  state;
      logic [5:0]      bitCnt;
      logic [PH_W-1:0] ph;
      logic [63:0]     sh;
      logic            isWr;
      logic [15:0]     rd;
      logic            ack;
      logic            done;
      logic            mdc;
      logic            out;
      logic            oe;
   } mucp_fr_st_t;

   mucp_fr_st_t q;
   mucp_fr_st_t d;

   always_comb
   begin
      d      = q;
      d.done = 1'b0;
      case (q.state)
         FR_IDLE:
         begin
            d.mdc = 1'b0;
            d.oe  = 1'b0;
            if (start)
            begin
               d.state  = FR_RUN;
               d.bitCnt = 6'h00;
               d.ph     = '0;
               d.isWr   = isWrite;
               d.ack    = 1'b0;
               // preamble, start, opcode, addresses, turnaround, data
               d.sh     = {FR_PREAMBLE, FR_START, isWrite ? FR_OP_WRITE : FR_OP_READ,
                           phyIdx, regIdx, FR_TA_DRIVE, wrData};
            end
         end
         FR_RUN:
         begin
            d.ph = q.ph + 1'b1;
            if (q.ph == '0)
            begin
               // new bit launched on the falling edge of mdc
               d.mdc = 1'b0;
               d.out = q.sh[63];
               // on reads the phy owns turnaround and data
               d.oe  = q.isWr || (q.bitCnt < FR_TA_FIRST);
            end
            if (q.ph == PH_HI)
               d.mdc = 1'b1;
            if (q.ph == PH_END)
            begin
               // late in the high phase, so the sync delay still lands inside it
               d.ph = '0;
               d.sh = {q.sh[62:0], 1'b0};
               if (q.bitCnt == FR_TA_LAST)
                  d.ack = !mdioSync;
               if (q.bitCnt >= FR_DATA_1ST)
                  d.rd = {q.rd[14:0], mdioSync};
               if (q.bitCnt == FR_LAST)
               begin
                  d.state = FR_IDLE;
                  d.done  = 1'b1;
               end
               else
                  d.bitCnt = q.bitCnt + 1'b1;
            end
         end
         default:
            d.state = FR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= d;
   end

   assign done    = q.done;
   assign ackSeen = q.ack;
   assign rdData  = q.rd;
   assign mdc     = q.mdc;
   assign mdioOut = q.out;
   assign mdioOe  = q.oe;

endmodule

// File: test/mucp_phy_model.sv
// mucp_phy_model: behavioural clause 22 phy answering at one address
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
module mucp_phy_model
  #(parameter logic [4:0] MY_ADDR = 5'h05)
  (
   input  wire logic        rst_b,     // async reset, active low
   input  wire logic        mdc,       // management clock
   input  wire logic        mdio,      // resolved data line
   input  wire logic        linkUp,    // link state in register 1 bit 2
   output logic             phyOut,    // value the phy drives
   output logic             phyOe,     // phy drives the line
   output logic             lastWrite, // last frame was a write
   output logic [4:0]       lastPhy,   // last frame phy address
   output logic [4:0]       lastReg,   // last frame register
   output logic [15:0]      lastData   // last frame data
  );
   logic [15:0] regs [32];
   logic [13:0] hdr;
   logic [15:0] sh;
   logic [15:0] rdVal;
   logic        answer;
   int          ones;
   int          idx;

   // sample on the rising edge, as a real phy does
   always @(posedge mdc or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ones = 0;
         idx = 0;
         answer = 1'b0;
      end
      else if (idx == 0)
      begin
         idx = (!mdio && ones >= 32) ? 33 : 0;
         ones = mdio ? ones + 1 : 0;
         hdr = 14'h0000;
      end
      else
      begin
         if (idx <= 45)
            hdr = {hdr[12:0], mdio};
         else if (idx >= 48)
            sh = {sh[14:0], mdio};
         if (idx == 45)
         begin
            answer = hdr[11:10] == 2'h2 && hdr[9:5] == MY_ADDR;
            rdVal = (hdr[4:0] == 5'h01) ? {13'h0000, linkUp, 2'h0} : regs[hdr[4:0]];
         end
         if (idx == 63)
         begin
            lastWrite = hdr[11:10] == 2'h1;
            lastPhy = hdr[9:5];
            lastReg = hdr[4:0];
            lastData = lastWrite ? sh : rdVal;
            if (lastWrite && hdr[9:5] == MY_ADDR)
               regs[hdr[4:0]] = sh;
            answer = 1'b0;
            idx = 0;
         end
         else
            idx = idx + 1;
      end
   end

   // drive from the falling edge so a bit stands its whole period
   always @(negedge mdc or negedge rst_b)
   begin
      if (!rst_b)
      begin
         phyOe = 1'b0;
         phyOut = 1'b0;
      end
      else
      begin
         phyOe = answer && idx >= 47;
         phyOut = (idx >= 48) ? rdVal[63 - idx] : 1'b0;
      end
   end
endmodule

// File: test/testbench.sv
// testbench: register-level tests of the mdio user command port
// assumes one behavioural phy on the data line, released line pulled high
`timescale 1ns/1ps
module testbench;
   import mucp_pkg::*;
   localparam logic [4:0] PHY = 5'h05;
   logic          clk = 1'b0;
   logic          rst_b = 1'b0;
   logic [AW-1:0] address = 8'h00;
   logic          read = 1'b0;
   logic          write = 1'b0;
   logic [31:0]   writedata = 32'h0000_0000;
   logic [3:0]    byteenable = 4'hF;
   logic          linkUp = 1'b0;
   logic [31:0]   readdata;
   logic [31:0]   rd;
   logic          waitrequest;
   logic          irq;
   logic          mdc;
   logic          mdioOut;
   logic          mdioOe;
   logic          phyOut;
   logic          phyOe;
   logic          mdioLine;
   logic          lastWrite;
   logic [4:0]    lastPhy;
   logic [4:0]    lastReg;
   logic [15:0]   lastData;
   int            errCount = 0;
   int            samplesChecked = 0;
   int            cycles = 0;

   always #12.5 clk = ~clk;
   assign mdioLine = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);

   mucp_top #(.MDC_HALF(4)) dut (
      .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .mdc(mdc), .mdioIn(mdioLine),
      .mdioOut(mdioOut), .mdioOe(mdioOe));

   mucp_phy_model #(.MY_ADDR(PHY)) phy (
      .rst_b(rst_b), .mdc(mdc), .mdio(mdioLine), .linkUp(linkUp), .phyOut(phyOut),
      .phyOe(phyOe), .lastWrite(lastWrite), .lastPhy(lastPhy), .lastReg(lastReg),
      .lastData(lastData));

   task automatic completeRun;
      $display("mismatches %0d of %0d checks", errCount, samplesChecked);
      if (errCount == 0 && samplesChecked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         errCount++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // called just after a rising edge; returns just after one
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      address <= a;
      read <= ~wr;
      write <= wr;
      writedata <= d;
      // no local limit: only the cycle ceiling ends a stalled wait
      do
      begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rreg(input logic [7:0] a, input string nm, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(nm, rd, exp);
   endtask

   // a poll frame may be running, so allow two frames and margin
   task automatic waitGo;
      int n;
      n = 0;
      do
      begin
         bus(1'b0, OFS_CMD, 32'h0000_0000);
         n++;
      end while (rd[31] !== 1'b0 && n < 1000);
      if (n >= 1000)
         errCount++;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         errCount++;
         completeRun;
      end
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rreg(OFS_CMD, "cmd reset", 32'h0000_0000);
      rreg(OFS_SEL, "sel reset", 32'h0000_0000);
      rreg(OFS_STAT, "stat reset", 32'h0000_0000);
      rreg(OFS_CTL, "ctl reset", 32'h0000_0000);
      rreg(8'h18, "unmapped", 32'h0000_0000);
      bus(1'b1, OFS_CMD, 32'hD065_1234);
      rreg(OFS_CMD, "go while off", 32'h4065_1234);
      byteenable <= 4'h1;
      bus(1'b1, OFS_CMD, 32'hFFFF_FFFF);
      byteenable <= 4'hF;
      rreg(OFS_CMD, "byte lane", 32'h4065_12FF);
      bus(1'b1, OFS_MASK, 32'h0000_0001);
      bus(1'b1, OFS_CTL, 32'h0000_0001);
      // a launch bit of 0 must not start anything
      bus(1'b1, OFS_CMD, 32'h4065_5A5A);
      rreg(OFS_CMD, "go zero", 32'h4065_5A5A);
      bus(1'b1, OFS_CMD, 32'hC065_A5C3);
      bus(1'b1, OFS_CMD, 32'h0000_0000);
      waitGo;
      check("cmd after write", rd, 32'h4065_A5C3);
      check("frame op", 32'(lastWrite), 32'h0000_0001);
      check("frame phy", 32'(lastPhy), 32'(PHY));
      check("frame reg", 32'(lastReg), 32'h0000_0003);
      check("frame data", 32'(lastData), 32'h0000_A5C3);
      check("irq done", 32'(irq), 32'h0000_0001);
      rreg(OFS_STAT, "stat done", 32'h0000_0001);
      @(posedge clk);
      check("irq cleared", 32'(irq), 32'h0000_0000);
      bus(1'b1, OFS_CMD, 32'h8065_0000);
      waitGo;
      check("read cmd", rd, 32'h2065_A5C3);
      check("read op", 32'(lastWrite), 32'h0000_0000);
      bus(1'b1, OFS_CMD, 32'h8069_0000);
      waitGo;
      check("no ack", 32'(rd[31:16]), 32'h0000_0069);
      check("nak phy", 32'(lastPhy), 32'h0000_0009);
      bus(1'b1, OFS_MASK, 32'h0000_0000);
      bus(1'b0, OFS_STAT, 32'h0000_0000);
      bus(1'b1, OFS_CMD, 32'hC065_0001);
      waitGo;
      check("masked irq", 32'(irq), 32'h0000_0000);
      rreg(OFS_STAT, "masked stat", 32'h0000_0001);
      bus(1'b1, OFS_SEL, 32'hFFFF_FFFF);
      rreg(OFS_SEL, "sel fields", 32'h0000_005F);
      // watching an absent phy must not see the link of ours
      bus(1'b1, OFS_SEL, 32'h0000_0049);
      bus(1'b1, OFS_MASK, 32'h0000_0002);
      linkUp <= 1'b1;
      repeat (1500) @(posedge clk);
      rreg(OFS_STAT, "other phy", 32'h0000_0000);
      bus(1'b1, OFS_SEL, 32'h0000_0045);
      for (int n = 0; n < 2000 && irq !== 1'b1; n++)
         @(posedge clk);
      check("link irq", 32'(irq), 32'h0000_0001);
      rreg(OFS_LINK, "link state", 32'h0000_0001);
      rreg(OFS_STAT, "stat link", 32'h0000_0002);
      bus(1'b1, OFS_SEL, 32'h0000_0005);
      linkUp <= 1'b0;
      repeat (1500) @(posedge clk);
      check("link irq off", 32'(irq), 32'h0000_0000);
      rreg(OFS_STAT, "stat off", 32'h0000_0000);
      rreg(OFS_LINK, "link down", 32'h0000_0000);
      completeRun;
   end
endmodule
